// file: common/radio_irq_pkg.sv
`default_nettype none

package radio_irq_pkg;

  // Bus geometry.
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned SRC_N  = 10;

  // Register byte addresses.
  localparam logic [31:0] MASK_ADDR = 32'h4000_000C;
  localparam logic [31:0] STAT_ADDR = 32'h4000_0010;
  localparam logic [31:0] RAW_ADDR  = 32'h4000_0014;
  localparam logic [31:0] ACK_ADDR  = 32'h4000_0018;
  localparam logic [31:0] TRIG_ADDR = 32'h4000_0040;

  // Source bit positions, shared by every view, and the enable register's during-event bit.
  localparam int unsigned SOFT_BIT  = 9;
  localparam int unsigned ABORT_BIT = 8;
  localparam int unsigned FINE_BIT  = 7;
  localparam int unsigned GROSS_BIT = 6;
  localparam int unsigned FAULT_BIT = 5;
  localparam int unsigned CIPH_BIT  = 4;
  localparam int unsigned REND_BIT  = 3;
  localparam int unsigned WAKE_BIT  = 2;
  localparam int unsigned RXP_BIT   = 1;
  localparam int unsigned TICK_BIT  = 0;
  localparam int unsigned TICK_DEV_BIT = 15;

  // Reset values and writable bits.
  localparam logic [31:0] MASK_RST   = 32'h0000_811F;
  localparam logic [31:0] MASK_WBITS = 32'h0000_83FF;
  localparam logic [9:0]  STAT_RST   = 10'h000;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

  // One flag per source, most significant first.
  typedef struct packed {
    logic soft_trigger;
    logic event_or_prefetch_abort;
    logic fine_timer;
    logic gross_timer;
    logic fault;
    logic cipher;
    logic radio_event_end;
    logic wake;
    logic packet_received;
    logic base_tick;
  } irq_vec_t;

endpackage

`default_nettype wire

// file: hdl/radio_core_interrupt_status.sv

`default_nettype none

module radio_core_interrupt_status #(
  parameter int unsigned ADDR_W = radio_irq_pkg::ADDR_W
) (
  // Clock, reset and freeze.
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,

  // APB slave.
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,

  // Event pulses from the link-layer sources.
  input  wire radio_irq_pkg::irq_vec_t src_event,
  input  wire logic                    event_active,

  // Interrupt request.
  output logic                         irq
);

  // The decoder compares whole 32-bit byte addresses, so a narrower
  // address bus cannot be served.
  if (ADDR_W != 32) begin : g_bad_addr_w
    $error("ADDR_W must be 32.");
  end

  // State.
  radio_irq_pkg::irq_vec_t raw_r;
  radio_irq_pkg::irq_vec_t raw_nxt;
  logic [31:0]             mask_r;
  logic [31:0]             mask_nxt;
  logic [31:0]             prdata_r;
  logic [31:0]             prdata_nxt;
  logic                    pslverr_r;
  logic                    pslverr_nxt;
  logic                    irq_r;
  logic                    irq_nxt;

  // Bus phase decode.
  logic                    cap_en;
  logic                    access_ph;
  logic                    wr_fire;
  logic                    loaded_r;
  logic                    loaded_nxt;

  // Address decode.
  logic                    hit_mask;
  logic                    hit_stat;
  logic                    hit_raw;
  logic                    hit_ack;
  logic                    hit_trig;
  logic                    hit_any;
  logic                    hit_ro;

  // Write data after the byte strobes.
  logic [31:0]             lane_bits;
  logic [31:0]             wr_bits;

  // Per-source controls.
  logic [9:0]              ack_vec;
  logic [9:0]              trig_vec;
  logic [9:0]              set_vec;
  logic [9:0]              masked_vec;
  logic                    tick_allowed;

  // The read word and error are taken once per transfer, at the first
  // running edge that sees psel. pready waits for that capture and for
  // the clock enable, so a setup edge lost to a freeze costs one more
  // access cycle instead of handing back a stale word, and a frozen
  // block stretches the access phase instead of losing a write.
  assign pready     = clk_en & loaded_r;
  assign cap_en     = psel & ~loaded_r;
  assign loaded_nxt = psel & ~(penable & loaded_r);
  assign access_ph  = psel & penable;
  assign wr_fire    = access_ph & pwrite & pready;

  // Full-address compare; anything else is an error.
  assign hit_mask = (paddr == radio_irq_pkg::MASK_ADDR);
  assign hit_stat = (paddr == radio_irq_pkg::STAT_ADDR);
  assign hit_raw  = (paddr == radio_irq_pkg::RAW_ADDR);
  assign hit_ack  = (paddr == radio_irq_pkg::ACK_ADDR);
  assign hit_trig = (paddr == radio_irq_pkg::TRIG_ADDR);
  assign hit_any  = hit_mask | hit_stat | hit_raw | hit_ack | hit_trig;
  assign hit_ro   = hit_stat | hit_raw;

  // Byte strobes select which lanes a write touches.
  assign lane_bits = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wr_bits   = pwdata & lane_bits;

  // Acknowledge bits act for one cycle and are never stored.
  assign ack_vec  = (wr_fire && hit_ack) ? wr_bits[9:0] : 10'h000;

  // The trigger register only raises the software source.
  assign trig_vec = (wr_fire && hit_trig) ?
                    {wr_bits[radio_irq_pkg::SOFT_BIT], 9'h000} : 10'h000;

  // Base ticks that land inside a radio event are dropped unless the
  // during-event enable is set; the tick is periodic, so one lost edge
  // only delays the next report by a tick period.
  assign tick_allowed = src_event.base_tick &
                        (mask_r[radio_irq_pkg::TICK_DEV_BIT] | ~event_active);

  // New events of this cycle, one bit per source.
  assign set_vec = {src_event.soft_trigger | trig_vec[radio_irq_pkg::SOFT_BIT],
                    src_event.event_or_prefetch_abort,
                    src_event.fine_timer,
                    src_event.gross_timer,
                    src_event.fault,
                    src_event.cipher,
                    src_event.radio_event_end,
                    src_event.wake,
                    src_event.packet_received,
                    tick_allowed};

  // Flags are sticky: they hold until acknowledged, and an event in the
  // cycle of its own acknowledge survives so nothing is lost.
  assign raw_nxt = radio_irq_pkg::irq_vec_t'(set_vec | (raw_r & ~ack_vec));

  // Mask writes keep reserved bits at zero.
  assign mask_nxt = (wr_fire && hit_mask) ?
                    ((mask_r & ~(lane_bits & radio_irq_pkg::MASK_WBITS)) |
                     (wr_bits & radio_irq_pkg::MASK_WBITS)) : mask_r;

  // The masked view is the raw view gated by the enables.
  assign masked_vec = raw_r & mask_r[9:0];

  // The request is registered from next state so it tracks the view.
  assign irq_nxt = |(raw_nxt & mask_nxt[9:0]);

  // Named flags of the masked view.
  logic soft_trigger_pending_masked;
  logic event_or_prefetch_abort_masked;
  logic fine_timer_pending_masked;
  logic gross_timer_pending_masked;
  logic fault_pending_masked;
  logic cipher_pending_masked;
  logic radio_event_end_masked;
  logic wake_pending_masked;
  logic packet_received_masked;
  logic base_tick_pending_masked;

  // Named flags of the raw view.
  logic soft_trigger_pending_raw;
  logic event_or_prefetch_abort_raw;
  logic fine_timer_pending_raw;
  logic gross_timer_pending_raw;
  logic fault_pending_raw;
  logic cipher_pending_raw;
  logic radio_event_end_raw;
  logic wake_pending_raw;
  logic packet_received_raw;
  logic base_tick_pending_raw;

  // Masked flags at their bit positions.
  assign soft_trigger_pending_masked    = masked_vec[radio_irq_pkg::SOFT_BIT];
  assign event_or_prefetch_abort_masked = masked_vec[radio_irq_pkg::ABORT_BIT];
  assign fine_timer_pending_masked      = masked_vec[radio_irq_pkg::FINE_BIT];
  assign gross_timer_pending_masked     = masked_vec[radio_irq_pkg::GROSS_BIT];
  assign fault_pending_masked           = masked_vec[radio_irq_pkg::FAULT_BIT];
  assign cipher_pending_masked          = masked_vec[radio_irq_pkg::CIPH_BIT];
  assign radio_event_end_masked         = masked_vec[radio_irq_pkg::REND_BIT];
  assign wake_pending_masked            = masked_vec[radio_irq_pkg::WAKE_BIT];
  assign packet_received_masked         = masked_vec[radio_irq_pkg::RXP_BIT];
  assign base_tick_pending_masked       = masked_vec[radio_irq_pkg::TICK_BIT];

  // Raw flags ignore the enables, except the during-event enable that gates the base tick.
  assign soft_trigger_pending_raw    = raw_r.soft_trigger;
  assign event_or_prefetch_abort_raw = raw_r.event_or_prefetch_abort;
  assign fine_timer_pending_raw      = raw_r.fine_timer;
  assign gross_timer_pending_raw     = raw_r.gross_timer;
  assign fault_pending_raw           = raw_r.fault;
  assign cipher_pending_raw          = raw_r.cipher;
  assign radio_event_end_raw         = raw_r.radio_event_end;
  assign wake_pending_raw            = raw_r.wake;
  assign packet_received_raw         = raw_r.packet_received;
  assign base_tick_pending_raw       = raw_r.base_tick;

  // Read words assembled from the named flags.
  logic [31:0] stat_word;
  logic [31:0] raw_word;

  assign stat_word = {22'h000000,
                      soft_trigger_pending_masked,
                      event_or_prefetch_abort_masked,
                      fine_timer_pending_masked,
                      gross_timer_pending_masked,
                      fault_pending_masked,
                      cipher_pending_masked,
                      radio_event_end_masked,
                      wake_pending_masked,
                      packet_received_masked,
                      base_tick_pending_masked};

  assign raw_word = {22'h000000,
                     soft_trigger_pending_raw,
                     event_or_prefetch_abort_raw,
                     fine_timer_pending_raw,
                     gross_timer_pending_raw,
                     fault_pending_raw,
                     cipher_pending_raw,
                     radio_event_end_raw,
                     wake_pending_raw,
                     packet_received_raw,
                     base_tick_pending_raw};

  // Read data is captured at the setup edge, which keeps prdata a
  // flip-flop at the cost of showing state one edge before the access;
  // an event landing between capture and completion shows on the next
  // read. Acknowledge and trigger registers read as zero.
  assign prdata_nxt = !cap_en   ? prdata_r :
                      hit_mask  ? mask_r :
                      hit_stat  ? stat_word :
                      hit_raw   ? raw_word :
                      radio_irq_pkg::RD_ZERO;

  // Unmapped addresses and writes to the two views answer with an error;
  // such a write changes nothing, so the views stay read-only.
  assign pslverr_nxt = cap_en ? (~hit_any | (pwrite & hit_ro)) :
                       pslverr_r;

  // Bus answer.
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  // Pending flags.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      raw_r <= radio_irq_pkg::irq_vec_t'(radio_irq_pkg::STAT_RST);
    end else if (clk_en) begin
      raw_r <= raw_nxt;
    end
  end

  // Enable register.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask_r <= radio_irq_pkg::MASK_RST;
    end else if (clk_en) begin
      mask_r <= mask_nxt;
    end
  end

  // Bus read data and error.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata_r  <= radio_irq_pkg::RD_ZERO;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Capture flag of the current transfer; it clears at the completing
  // edge so that a back-to-back setup captures afresh.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      loaded_r <= 1'b0;
    end else if (clk_en) begin
      loaded_r <= loaded_nxt;
    end
  end

  // Interrupt request level.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else if (clk_en) begin
      irq_r <= irq_nxt;
    end
  end

endmodule

`default_nettype wire

// file: bench/radio_core_interrupt_status_monitor.sv
`default_nettype none

module radio_irq_monitor #(
  parameter int unsigned ADDR_W = 32
) (
  // Clock and control.
  input wire logic                    clock,
  input wire logic                    sys_rst,
  input wire logic                    clk_en,
  // Register bus.
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [ADDR_W-1:0]       paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // Events and request.
  input wire radio_irq_pkg::irq_vec_t src_event,
  input wire logic                    event_active,
  input wire logic                    irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // Only a completed write or a reset may lower the request, and only a write may raise it without an event.
  wire logic setup  = psel && !penable && clk_en;
  wire logic wr_acc = psel && penable && pwrite && pready;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_stat_wr_refused: assert property (setup && pwrite && paddr == 32'h4000_0010 |=> pslverr)
    else $error("write to masked view not refused");
  a_raw_wr_refused: assert property (setup && pwrite && paddr == 32'h4000_0014 |=> pslverr)
    else $error("write to raw view not refused");
  a_view_rd_clean: assert property (setup && !pwrite && paddr[31:3] == 29'h0800_0002
    |=> !pslverr && prdata[31:10] == 22'h0) else $error("view read flagged or dirty");
  a_ack_reads_zero: assert property (setup && !pwrite && paddr == 32'h4000_0018 |=> !prdata)
    else $error("acknowledge register read not zero");
  a_irq_held: assert property (irq && !wr_acc |=> irq)
    else $error("request dropped without a write");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(src_event) != 10'h000 || $past(wr_acc))
    else $error("request rose without a cause");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_acc) || $past(sys_rst))
    else $error("request fell without a write");
  a_frozen_hold: assert property (!clk_en |=> $stable(irq) && $stable(prdata))
    else $error("state moved while frozen");
endmodule

bind radio_core_interrupt_status radio_irq_monitor #(.ADDR_W(ADDR_W)) mon (
  .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .src_event(src_event), .event_active(event_active),
  .irq(irq));

`default_nettype wire

// file: bench/host_apb_model.sv
`default_nettype none

module host_apb_model (
  // Clock.
  input  wire logic        clock,
  // Register bus, master side.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  bit timed_out = 1'b0;

  // Idle bus at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end

  // One transfer; acknowledges are plain writes of ones to the acknowledge word.
  // Released address and data lines are inverted so that a slave sampling late sees garbage, not old data.
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] rd, output logic err);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) timed_out = 1'b1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

`default_nettype wire

// file: bench/radio_core_interrupt_status_tb_top.sv
`default_nettype none

module radio_core_interrupt_status_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] msk_a = 32'h4000_000C;
  localparam logic [31:0] st_a  = 32'h4000_0010;
  localparam logic [31:0] raw_a = 32'h4000_0014;
  localparam logic [31:0] ack_a = 32'h4000_0018;
  // Bench signals.
  logic        clock, sys_rst, clk_en, event_active, psel, penable, pwrite, pready, pslverr, irq;
  logic        err;
  logic [9:0]  src_event;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          n_errors = 0;
  int          check_count = 0;

  radio_core_interrupt_status dut (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_event(src_event), .event_active(event_active),
    .irq(irq));
  host_apb_model host (
    .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free-running clock.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A bus cycle whose wait ran out ends the run as a mismatch.
  task automatic bus(input logic w, input logic [31:0] a, d);
    host.xfer(w, a, d, rd, err);
    if (host.timed_out) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  task automatic rdchk(input logic [31:0] a, exp, input string what);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic pulse(input logic [9:0] v);
    @(posedge clock);
    src_event <= v;
    @(posedge clock);
    src_event <= 10'h000;
  endtask

  // Each source alone under the reset enables, then acknowledged by its own bit.
  task automatic t_each_source();
    logic [31:0] b;
    for (int i = 0; i < 10; i++) begin
      b = 32'h1 << i;
      pulse(b[9:0]);
      rdchk(raw_a, b, "raw flag");
      rdchk(st_a, b & 32'h0000_011F, "masked flag");
      check("irq", {31'h0, irq}, {31'h0, |(b & 32'h0000_011F)});
      bus(1'b1, ack_a, b);
      rdchk(raw_a, 32'h0, "acked flag");
    end
  endtask

  // Disabled sources still show raw; a read begun in a freeze must still return them.
  task automatic t_mask_and_hold();
    bus(1'b1, msk_a, 32'h0);
    pulse(10'h3FF);
    rdchk(raw_a, 32'h0000_03FF, "raw unmasked");
    rdchk(st_a, 32'h0, "masked off");
    check("irq off", {31'h0, irq}, 32'h0);
    bus(1'b1, msk_a, 32'h0000_83FF);
    clk_en <= 1'b0;
    fork
      rdchk(st_a, 32'h0000_03FF, "masked on");
      begin
        repeat (4) @(posedge clock);
        check("pready frozen", {31'h0, pready}, 32'h0);
        clk_en <= 1'b1;
      end
    join
    check("irq on", {31'h0, irq}, 32'h1);
    bus(1'b1, ack_a, 32'h0000_0155);
    rdchk(raw_a, 32'h0000_02AA, "partial ack");
    check("irq left", {31'h0, irq}, 32'h1);
    bus(1'b1, ack_a, 32'h0000_02AA);
    @(posedge clock);
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  // Writes to the views, write-only and unmapped reads, then the software trigger.
  task automatic t_refusals();
    pulse(10'h002);
    bus(1'b1, st_a, 32'h0);
    check("view write err", {31'h0, err}, 32'h1);
    bus(1'b1, raw_a, 32'h0);
    check("raw write err", {31'h0, err}, 32'h1);
    rdchk(ack_a, 32'h0, "ack readback");
    rdchk(32'h4000_0030, 32'h0, "unmapped");
    check("unmapped err", {31'h0, err}, 32'h1);
    bus(1'b1, 32'h4000_0040, 32'h0000_0200);
    rdchk(raw_a, 32'h0000_0202, "views kept");
    bus(1'b1, ack_a, 32'h0000_0202);
  endtask

  // The base tick is dropped inside a radio event unless its event enable is set.
  task automatic t_tick_in_event();
    event_active <= 1'b1;
    bus(1'b1, msk_a, 32'h0000_0001);
    pulse(10'h001);
    rdchk(raw_a, 32'h0, "tick in event");
    bus(1'b1, msk_a, 32'h0000_8001);
    pulse(10'h001);
    rdchk(raw_a, 32'h0000_0001, "tick allowed");
    event_active <= 1'b0;
  endtask

  // Reset, then every scenario in turn.
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    event_active = 1'b0;
    src_event = 10'h000;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rdchk(st_a, 32'h0, "masked reset");
    rdchk(raw_a, 32'h0, "raw reset");
    rdchk(msk_a, 32'h0000_811F, "enables reset");
    t_each_source();
    t_mask_and_hold();
    t_refusals();
    t_tick_in_event();
    tally_and_finish();
  end
endmodule

`default_nettype wire
